// File: hdl/capture_pkg.sv
// Package: constants, register map and carrier types for the edge capture block
package capture_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PROC_SAMPLE_US = 125;
  localparam int unsigned PROC_SAMPLE_CYC = PROC_SAMPLE_US * CLK_MHZ;
  localparam int unsigned SERVO_CYC_DEF = 250000;
  localparam int unsigned ARM_LEAD_SERVO = 2;
  localparam int unsigned N_PROC = 12;
  localparam int unsigned N_ZERO = 4;
  localparam int unsigned N_LOCAL = 2;
  localparam int unsigned N_IN = N_ZERO + N_LOCAL;
  localparam int unsigned N_DOUT = 8;
  localparam int unsigned N_ENC = 4;
  localparam int unsigned N_OBJ = 4;
  localparam int unsigned POS_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 12;
  // Register byte addresses
  localparam logic [11:0] A_PROC = 12'h000;
  localparam logic [11:0] A_DOUT = 12'h004;
  localparam logic [11:0] A_ZMODE = 12'h008;
  localparam logic [11:0] A_REFSTAT = 12'h00C;
  localparam logic [11:0] A_REF0 = 12'h010;
  localparam logic [11:0] A_OBJ0 = 12'h100;
  localparam logic [11:0] OBJ_STRIDE = 12'h020;
  localparam logic [4:0] O_CFG = 5'h00;
  localparam logic [4:0] O_CMD = 5'h04;
  localparam logic [4:0] O_STAT = 5'h08;
  localparam logic [4:0] O_RES1 = 5'h0C;
  localparam logic [4:0] O_RES2 = 5'h10;
  localparam logic [4:0] O_CNT = 5'h14;
  localparam logic [4:0] O_TIME = 5'h18;
  // Object config fields
  localparam int unsigned F_SEL = 0;
  localparam int unsigned F_ENC = 4;
  localparam int unsigned F_CYC = 8;
  localparam int unsigned F_RISE = 9;
  localparam int unsigned F_FALL = 10;
  // Command bits
  localparam int unsigned C_ARM = 0;
  localparam int unsigned C_DISARM = 1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CFG_RST = 32'h0000_0600;

  typedef enum logic [2:0] {
    OBJ_IDLE = 3'b001,
    OBJ_ARMED = 3'b010,
    OBJ_TRIG = 3'b100
  } obj_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;
endpackage : capture_pkg

// File: hdl/edge_position_capture_inputs.sv
// Front connector inputs, outputs and encoder position capture with AXI4-Lite registers
// Operation
// - Eighteen inputs: twelve process, four zero, two local
// - Process inputs sampled every 125 us
// - Eight digital outputs numbered zero to seven
// - Local input edge latches encoder positions
// - Object input chosen by measuring input number
// - Enabled zero mark rising edge latches axis reference unless in global mode
// - Zero mark input n feeds axis n
// - Each zero input may act as global input
// - Global and local inputs work together
// - Global edge may latch any configured encoder
// - At most two edges per object per cycle
// - Several objects may share one encoder
// - One input may feed several objects
// - Single shot and cyclic rearming modes
// - Result and counter updated within two cycles
// - Store position, two slots; single shot sets triggered on second edge or edge at cycle end
// - Each slot counter increments per new value
module edge_position_capture_inputs
  import capture_pkg::*;
#(
  parameter int unsigned SERVO_CYC = SERVO_CYC_DEF
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [capture_pkg::N_PROC-1:0] process_inputs,
  input wire logic [capture_pkg::N_ZERO-1:0] zero_mark_global_inputs,
  input wire logic [capture_pkg::N_LOCAL-1:0] local_measure_inputs,
  input wire logic [capture_pkg::N_ENC*capture_pkg::POS_W-1:0] encoder_positions,
  output logic [capture_pkg::N_DOUT-1:0] digital_outputs,
  output logic servo_tick,
  input wire capture_pkg::axi_req_t axi_req,
  output capture_pkg::axi_rsp_t axi_rsp
);
  import capture_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [N_PROC+N_IN-1:0] meta_q, sync_q, prev_q;
  logic [N_IN-1:0] meas_lvl, rise, fall;
  always_ff @(posedge clock) begin
    meta_q <= {local_measure_inputs, zero_mark_global_inputs, process_inputs};
    sync_q <= meta_q;
    prev_q <= sync_q;
  end
  assign meas_lvl = sync_q[N_PROC+N_IN-1:N_PROC];
  assign rise = meas_lvl & ~prev_q[N_PROC+N_IN-1:N_PROC];
  assign fall = ~meas_lvl & prev_q[N_PROC+N_IN-1:N_PROC];

  // ----------------------------------------
  // Cycle timers
  // ----------------------------------------
  logic [$clog2(PROC_SAMPLE_CYC)-1:0] samp_cnt_q;
  logic [31:0] servo_cnt_q;
  logic [N_PROC-1:0] proc_q;
  logic servo_end;
  assign servo_end = servo_cnt_q == 32'(SERVO_CYC - 1);
  logic samp_end;
  assign samp_end = samp_cnt_q == $bits(samp_cnt_q)'(PROC_SAMPLE_CYC - 1);
  always_ff @(posedge clock) begin
    if (srst || samp_end) begin
      samp_cnt_q <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_q + 1'b1;
    end
  end
  // Snapshot keeps the process word coherent between samples
  always_ff @(posedge clock) begin
    if (srst) begin
      proc_q <= '0;
    end else if (samp_end) begin
      proc_q <= sync_q[N_PROC-1:0];
    end
  end
  always_ff @(posedge clock) begin
    if (srst || servo_end) begin
      servo_cnt_q <= '0;
    end else begin
      servo_cnt_q <= servo_cnt_q + 32'h0000_0001;
    end
  end
  // Registered so the tick pin comes straight from a flop
  always_ff @(posedge clock) begin
    servo_tick <= !srst && servo_end;
  end

  // ----------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------
  logic aw_q, w_q, bv_q, rv_q;
  logic [ADDR_W-1:0] awa_q, ara_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, rd_go, wr_hit, rd_hit;
  logic [31:0] rd_val;
  assign wr_go = aw_q && w_q && !bv_q;
  assign rd_go = axi_req.arvalid && !rv_q;
  // Address and data latch independently, so either may come first
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_q <= 1'b0;
      awa_q <= '0;
    end else if (wr_go) begin
      aw_q <= 1'b0;
    end else if (axi_req.awvalid && !aw_q) begin
      aw_q <= 1'b1;
      awa_q <= axi_req.awaddr;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      w_q <= 1'b0;
      wd_q <= '0;
    end else if (wr_go) begin
      w_q <= 1'b0;
    end else if (axi_req.wvalid && !w_q) begin
      w_q <= 1'b1;
      wd_q <= axi_req.wdata;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      bv_q <= 1'b0;
      bresp_q <= RESP_OK;
    end else if (wr_go) begin
      bv_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OK : RESP_SLVERR;
    end else if (bv_q && axi_req.bready) begin
      bv_q <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      rv_q <= 1'b0;
      rd_q <= '0;
      rresp_q <= RESP_OK;
    end else if (rd_go) begin
      rv_q <= 1'b1;
      rd_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OK : RESP_SLVERR;
    end else if (rv_q && axi_req.rready) begin
      rv_q <= 1'b0;
    end
  end
  always_comb begin
    axi_rsp.awready = !aw_q;
    axi_rsp.wready = !w_q;
    axi_rsp.bvalid = bv_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = !rv_q;
    axi_rsp.rvalid = rv_q;
    axi_rsp.rdata = rd_q;
    axi_rsp.rresp = rresp_q;
  end

  // ----------------------------------------
  // Global registers and zero marks
  // ----------------------------------------
  logic [N_DOUT-1:0] dout_q;
  logic [N_ZERO-1:0] zglob_q, zen_q, zhit_q;
  logic [POS_W-1:0] ref_q [N_ZERO];
  logic wr_glob, wr_dout, wr_zmode, wr_refstat;
  assign wr_glob = wr_go && awa_q < A_OBJ0;
  assign wr_dout = wr_glob && awa_q == A_DOUT;
  assign wr_zmode = wr_glob && awa_q == A_ZMODE;
  assign wr_refstat = wr_glob && awa_q == A_REFSTAT;
  always_ff @(posedge clock) begin
    if (srst) begin
      dout_q <= '0;
    end else if (wr_dout) begin
      dout_q <= wd_q[N_DOUT-1:0];
    end
  end
  // Mode change acts on the next edge; an edge in flight may be lost
  always_ff @(posedge clock) begin
    if (srst) begin
      zen_q <= '0;
      zglob_q <= '0;
    end else if (wr_zmode) begin
      zen_q <= wd_q[N_ZERO-1:0];
      zglob_q <= wd_q[2*N_ZERO-1:N_ZERO];
    end
  end
  assign digital_outputs = dout_q;
  // Zero inputs in global mode never touch the reference latch
  always_ff @(posedge clock) begin
    for (int z = 0; z < N_ZERO; z++) begin
      if (srst) begin
        ref_q[z] <= '0;
        zhit_q[z] <= 1'b0;
      end else if (zen_q[z] && !zglob_q[z] && rise[z]) begin
        ref_q[z] <= encoder_positions[z*POS_W +: POS_W];
        zhit_q[z] <= 1'b1;
      end else if (wr_refstat && wd_q[z]) begin
        zhit_q[z] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Measuring objects
  // ----------------------------------------
  logic [31:0] cfg_q [N_OBJ];
  obj_state_t st_q [N_OBJ];
  logic [POS_W-1:0] res1_q [N_OBJ], res2_q [N_OBJ];
  logic [CNT_W-1:0] cnt1_q [N_OBJ], cnt2_q [N_OBJ];
  logic [31:0] tim_q [N_OBJ];
  logic [1:0] edges_q [N_OBJ];
  logic [2:0] sel [N_OBJ];
  logic hit [N_OBJ];
  logic wr_obj [N_OBJ];
  logic cfg_wr [N_OBJ], arm_cmd [N_OBJ], disarm_cmd [N_OBJ];
  always_comb begin
    for (int o = 0; o < N_OBJ; o++) begin
      // Any object may point at any input: listeners share a source
      sel[o] = cfg_q[o][F_SEL +: 3];
      hit[o] = sel[o] < 3'(N_IN)
        && (sel[o] >= 3'(N_ZERO) || zglob_q[sel[o][1:0]])
        && ((cfg_q[o][F_RISE] && rise[sel[o]]) || (cfg_q[o][F_FALL] && fall[sel[o]]));
      wr_obj[o] = wr_go && awa_q[11:5] == 7'(8 + o);
      cfg_wr[o] = wr_obj[o] && awa_q[4:0] == O_CFG;
      arm_cmd[o] = wr_obj[o] && awa_q[4:0] == O_CMD && wd_q[C_ARM];
      disarm_cmd[o] = wr_obj[o] && awa_q[4:0] == O_CMD && wd_q[C_DISARM];
    end
  end
  always_ff @(posedge clock) begin
    for (int o = 0; o < N_OBJ; o++) begin
      if (srst) begin
        cfg_q[o] <= CFG_RST;
        st_q[o] <= OBJ_IDLE;
        res1_q[o] <= '0;
        res2_q[o] <= '0;
        cnt1_q[o] <= '0;
        cnt2_q[o] <= '0;
        tim_q[o] <= '0;
        edges_q[o] <= '0;
      end else begin
        if (cfg_wr[o]) begin
          cfg_q[o] <= wd_q;
        end
        if (servo_end) begin
          edges_q[o] <= '0;
        end
        unique case (st_q[o])
          OBJ_IDLE: begin
            if (arm_cmd[o]) begin
              st_q[o] <= OBJ_ARMED;
            end
          end
          OBJ_ARMED: begin
            if (disarm_cmd[o]) begin
              st_q[o] <= OBJ_IDLE;
            end else if (hit[o] && edges_q[o] != 2'd2) begin
              // Encoder chosen freely; several objects may share it
              if (edges_q[o] == 2'd0) begin
                res1_q[o] <= encoder_positions[cfg_q[o][F_ENC +: 2]*POS_W +: POS_W];
                cnt1_q[o] <= cnt1_q[o] + 1'b1;
              end else begin
                res2_q[o] <= encoder_positions[cfg_q[o][F_ENC +: 2]*POS_W +: POS_W];
                cnt2_q[o] <= cnt2_q[o] + 1'b1;
              end
              // Unread results are overwritten by design
              tim_q[o] <= servo_cnt_q;
              edges_q[o] <= servo_end ? 2'd0 : edges_q[o] + 2'd1;
              if (!cfg_q[o][F_CYC] && (edges_q[o] == 2'd1 || servo_end)) begin
                st_q[o] <= OBJ_TRIG;
              end
            end
          end
          OBJ_TRIG: begin
            if (arm_cmd[o]) begin
              st_q[o] <= OBJ_ARMED;
            end else if (disarm_cmd[o]) begin
              st_q[o] <= OBJ_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [ADDR_W-1:0] ra;
  logic [1:0] ro;
  assign ra = axi_req.araddr;
  assign ro = ra[6:5];
  // Only writable words answer OK; status and results are read-only
  always_comb begin
    wr_hit = awa_q == A_DOUT || awa_q == A_ZMODE || awa_q == A_REFSTAT
      || (awa_q[11:7] == A_OBJ0[11:7] && (awa_q[4:0] == O_CFG || awa_q[4:0] == O_CMD));
  end
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (ra == A_PROC) begin
      rd_val[N_PROC-1:0] = proc_q;
    end else if (ra == A_DOUT) begin
      rd_val[N_DOUT-1:0] = dout_q;
    end else if (ra == A_ZMODE) begin
      rd_val[N_ZERO+3:0] = {zglob_q, zen_q};
    end else if (ra == A_REFSTAT) begin
      rd_val[N_ZERO+7:0] = {meas_lvl[N_ZERO-1:0], zhit_q};
    end else if (ra >= A_REF0 && ra < A_REF0 + 12'h010 && ra[1:0] == 2'b00) begin
      rd_val = ref_q[ra[3:2]];
    end else if (ra[11:7] == A_OBJ0[11:7]) begin
      unique case (ra[4:0])
        O_CFG: begin
          rd_val = cfg_q[ro];
        end
        O_STAT: begin
          // Level shows input 0 when the selection is out of range
          rd_val = {24'h000000, 2'b00, meas_lvl[sel[ro] < 3'(N_IN) ? sel[ro] : 3'd0],
            edges_q[ro], st_q[ro]};
        end
        O_RES1: begin
          rd_val = res1_q[ro];
        end
        O_RES2: begin
          rd_val = res2_q[ro];
        end
        O_CNT: begin
          rd_val = {cnt2_q[ro], cnt1_q[ro]};
        end
        O_TIME: begin
          rd_val = tim_q[ro];
        end
        O_CMD: begin
          rd_val = '0;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end else begin
      rd_hit = 1'b0;
    end
  end
endmodule : edge_position_capture_inputs

// File: verification/capture_monitor.sv
// Checker: bus handshake, reset and servo tick properties
module capture_monitor #(
  parameter int unsigned SERVO_CYC = 100
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [capture_pkg::N_DOUT-1:0] digital_outputs,
  input wire logic servo_tick,
  input wire capture_pkg::axi_req_t axi_req,
  input wire capture_pkg::axi_rsp_t axi_rsp
);
  import capture_pkg::*;
  // --------
  // Tick spacing helper
  // --------
  logic [31:0] gap_q;
  logic seen_q;
  always_ff @(posedge clock) begin
    if (srst || servo_tick) gap_q <= '0;
    else gap_q <= gap_q + 32'h1;
  end
  // First tick after reset has no reference point
  always_ff @(posedge clock) begin
    seen_q <= srst ? 1'b0 : (seen_q | servo_tick);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_aw;
    axi_req.awvalid && axi_rsp.awready;
  endsequence
  sequence s_w;
    axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_ar;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  property p_wr_lat;
    s_aw and s_w |-> ##[1:3] axi_rsp.bvalid;
  endproperty
  property p_wr_busy;
    s_aw and s_w |=> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  property p_wr_hold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  property p_rd_lat;
    s_ar |=> axi_rsp.rvalid;
  endproperty
  property p_rd_hold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  property p_ar_block;
    axi_rsp.rvalid |-> !axi_rsp.arready;
  endproperty
  property p_unmapped;
    s_ar ##0 (axi_req.araddr == 12'hFFC) |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == '0;
  endproperty
  property p_rst_out;
    $fell(srst) |-> digital_outputs == '0 && axi_rsp.arready && !axi_rsp.rvalid && !axi_rsp.bvalid;
  endproperty
  property p_tick_gap;
    servo_tick && seen_q |-> gap_q == SERVO_CYC - 1;
  endproperty
  property p_tick_pulse;
    servo_tick |=> !servo_tick;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  a_wr_busy: assert property (p_wr_busy) else $error("write ready not dropped");
  a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_rst_out: assert property (p_rst_out) else $error("bad state after reset");
  a_tick_gap: assert property (p_tick_gap) else $error("servo period wrong");
  a_tick_pulse: assert property (p_tick_pulse) else $error("servo tick too long");
endmodule : capture_monitor

bind edge_position_capture_inputs capture_monitor #(.SERVO_CYC(SERVO_CYC)) u_mon (
  .clock(clock),
  .srst(srst),
  .digital_outputs(digital_outputs),
  .servo_tick(servo_tick),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp)
);

// File: verification/edge_position_capture_inputs_tb.sv
// Testbench: register access, zero marks and edge capture
module edge_position_capture_inputs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  // --------
  // Signals
  // --------
  localparam int unsigned SC = 100;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [N_PROC-1:0] proc = '0;
  logic [N_ENC*POS_W-1:0] enc;
  logic [N_ZERO-1:0] zpin;
  logic [N_LOCAL-1:0] lpin;
  logic [N_DOUT-1:0] dout;
  logic tick;
  axi_req_t rq = '0;
  axi_rsp_t rs;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 32'h6DF80CDC;
  logic [65:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [65:0] note;
  logic [31:0] v;
  logic [31:0] w;
  always #2 clock = ~clock;
  edge_position_capture_inputs #(.SERVO_CYC(SC)) u_dut (
    .clock(clock),
    .srst(srst),
    .process_inputs(proc),
    .zero_mark_global_inputs(zpin),
    .local_measure_inputs(lpin),
    .encoder_positions(enc),
    .digital_outputs(dout),
    .servo_tick(tick),
    .axi_req(rq),
    .axi_rsp(rs)
  );
  field_side_model u_far (
    .clock(clock),
    .enc_pos(enc),
    .zero_pins(zpin),
    .local_pins(lpin)
  );
  // --------
  // Tasks
  // --------
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t data got %h exp %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t resp got %h exp %h", $time, got, exp);
    end
  endtask : check_resp
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OK);
    wr_q.push_back(e);
    @(posedge clock);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    fork
      begin
        do @(posedge clock); while (rs.awready !== 1'b1);
        rq.awvalid <= 1'b0;
      end
      begin
        do @(posedge clock); while (rs.wready !== 1'b1);
        rq.wvalid <= 1'b0;
      end
    join
    do @(posedge clock); while (rs.bvalid !== 1'b1);
    rq.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] e = RESP_OK);
    rd_q.push_back({e, m, d});
    @(posedge clock);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do @(posedge clock); while (rs.arready !== 1'b1);
    rq.arvalid <= 1'b0;
    do @(posedge clock); while (rs.rvalid !== 1'b1);
    rq.rready <= 1'b0;
  endtask : rd
  function automatic logic [11:0] oa(input int o, input logic [4:0] f);
    return A_OBJ0 + OBJ_STRIDE * 12'(o) + 12'(f);
  endfunction : oa
  task automatic wait_tick();
    do @(posedge clock); while (tick !== 1'b1);
  endtask : wait_tick
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // --------
  // Result watcher
  // --------
  always @(posedge clock) begin
    if (rs.rvalid === 1'b1 && rq.rready === 1'b1) begin
      note = rd_q.pop_front();
      check_data(rs.rdata & note[63:32], note[31:0]);
      check_resp(rs.rresp, note[65:64]);
    end
    if (rs.bvalid === 1'b1 && rq.bready === 1'b1) check_resp(rs.bresp, wr_q.pop_front());
  end
  // Long enough for one process sample period plus the captures
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    stop_test();
  end
  // --------
  // Scenarios
  // --------
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rd(oa(0, O_CFG), CFG_RST);
    rd(oa(0, O_STAT), 32'h1, 32'h7);
    rd(12'hFFC, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(A_PROC, 32'h0, RESP_SLVERR);
    v = $random(seed);
    wr(A_DOUT, v);
    rd(A_DOUT, v & 32'hFF, 32'hFF);
    check_data({24'h0, dout}, v & 32'hFF);
    proc <= v[19:8];
    repeat (PROC_SAMPLE_CYC + 8) @(posedge clock);
    rd(A_PROC, {20'h0, v[19:8]}, 32'hFFF);
    wr(A_ZMODE, 32'hF);
    for (int z = 0; z < 4; z++) begin
      v = $random(seed);
      u_far.move(z, v);
      u_far.drive(4'(1 << z), 2'h0);
      repeat (8) @(posedge clock);
      u_far.drive(4'h0, 2'h0);
      rd(A_REF0 + 12'(4 * z), v);
    end
    rd(A_REFSTAT, 32'hF, 32'hF);
    wr(A_ZMODE, 32'h10);
    wr(oa(0, O_CFG), 32'h0000_0614);
    wr(oa(1, O_CFG), 32'h0000_0320);
    wr(oa(2, O_CFG), 32'h0000_0220);
    for (int o = 0; o < 3; o++) wr(oa(o, O_CMD), 32'h1);
    for (int o = 0; o < 3; o++) rd(oa(o, O_STAT), 32'h2, 32'h7);
    // Arming lead of two servo cycles before any edge
    repeat (3) wait_tick();
    repeat (5) @(posedge clock);
    v = $random(seed);
    w = $random(seed);
    u_far.move(1, v);
    u_far.move(2, ~v);
    u_far.drive(4'h1, 2'h1);
    repeat (20) @(posedge clock);
    u_far.move(1, w);
    u_far.drive(4'h0, 2'h0);
    wait_tick();
    repeat (3) @(posedge clock);
    // All results fetched before any further edge
    rd(oa(0, O_RES1), v);
    rd(oa(0, O_RES2), w);
    rd(oa(0, O_CNT), 32'h0001_0001);
    rd(oa(0, O_STAT), 32'h4, 32'h7);
    rd(oa(1, O_RES1), ~v);
    rd(oa(2, O_RES1), ~v);
    rd(oa(1, O_STAT), 32'h2, 32'h7);
    repeat (4) @(posedge clock);
    stop_test();
  end
endmodule : edge_position_capture_inputs_tb

// File: verification/field_side_model.sv
// Field side model: encoder positions and switch inputs
module field_side_model (
  input wire logic clock,
  output logic [capture_pkg::N_ENC*capture_pkg::POS_W-1:0] enc_pos,
  output logic [capture_pkg::N_ZERO-1:0] zero_pins,
  output logic [capture_pkg::N_LOCAL-1:0] local_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  // --------
  // Positions only move when told, so a capture has one right answer
  // --------
  initial begin
    enc_pos = '0;
    zero_pins = '0;
    local_pins = '0;
  end
  task automatic move(input int e, input logic [31:0] p);
    @(posedge clock);
    enc_pos[e*POS_W +: POS_W] <= p;
  endtask : move
  task automatic drive(input logic [3:0] z, input logic [1:0] l);
    @(posedge clock);
    zero_pins <= z;
    local_pins <= l;
  endtask : drive
endmodule : field_side_model
